// *** rtl/irq_prio_regs.svh ***
// Register offsets, field positions and reset values of the interrupt enable and priority block
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_ENABLE2     8'hA9
`define OFS_PRIO_LO0    8'hB8
`define OFS_PRIO_HI0    8'hB9
`define OFS_PRIO_LO1    8'hBA
`define OFS_PRIO_HI1    8'hBB
`define OFS_GLOBAL_EN   8'hA8
`define OFS_STATUS      8'hC0
`define OFS_CLEAR       8'hC1
`define OFS_EVT_EN      8'hC2
`define OFS_SERVICE     8'hC3

// ----------------------------------------
// Fields and masks
// ----------------------------------------
`define BIT_GLOBAL_EN   7
`define BIT_FLASH_WE    6
`define BIT_PIN2_EN     2
`define MASK_ENABLE2    8'h5F
`define MASK_GLOBAL     8'hBF
`define MASK_PRIO0      8'h3F
`define MASK_PRIO1      8'h1F
`define PIN2_SRC        9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE        8'h00
`define RST_SRC         11'h000
`define RST_EVT         3'h0

`endif

// *** rtl/irq_prio_pkg.sv ***
// Types for the interrupt enable and priority block
package irq_prio_pkg;

    typedef logic [1:0] prio_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ENTER = 2'b01
    } entry_state_e;

    typedef struct packed {
        logic       valid;
        logic [3:0] source;
        prio_t      level;
    } grant_s;

endpackage

// *** rtl/irq_prio_ctrl.sv ***
// Interrupt enable, priority selection and nested service tracking
//
// How it works
// RULE1 - Level is high bit over low bit
// RULE2 - Timer2 level from bank0 bit 5
// RULE3 - Serial port level from bank0 bit 4
// RULE4 - Timer1 level from bank0 bit 3
// RULE5 - Pin 1 level from bank0 bit 2
// RULE6 - Timer0 level from bank0 bit 1
// RULE7 - Pin 0 level from bank0 bit 0
// RULE8 - SPI level from bank1 bit 4
// RULE9 - Touch key level from bank1 bit 3
// RULE10 - Pin 2 level from bank1 bit 2
// RULE11 - Port change level from bank1 bit 1
// RULE12 - Timer3 level from bank1 bit 0
// RULE13 - Timer3 serviced only when its enable set
// RULE14 - Enable bits 4..0, all reset zero
// RULE15 - Pin 2 enable wakes stop, ignores global
// RULE16 - Higher level preempts lower running routine
// RULE17 - Equal or higher running holds new request
// RULE18 - Flags set regardless of enable
`timescale 1ns/1ps
`include "irq_prio_regs.svh"

module irq_prio_ctrl
    import irq_prio_pkg::*;
#(
    parameter int NSRC = 11
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    // Register port
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic      [7:0]       reg_rdata_o,
    // Source events and flags
    input  wire logic [NSRC-1:0]  src_event_i,
    input  wire logic [NSRC-1:0]  src_flag_clr_i,
    output logic      [NSRC-1:0]  src_flag_o,
    // Core side
    input  wire logic             ack_i,
    input  wire logic             reti_i,
    input  wire logic             stop_mode_i,
    output logic                  req_o,
    output logic      [3:0]       req_src_o,
    output logic      [1:0]       req_level_o,
    output logic                  stop_wake_o,
    output logic                  flash_write_en_o,
    output logic                  irq_o
);

    // ----------------------------------------
    // Source index order
    // ----------------------------------------
    // 0 pin0, 1 timer0, 2 pin1, 3 timer1, 4 serial, 5 timer2,
    // 6 timer3, 7 port change, 8 pin2, 9 touch, 10 spi
    // Pin2 sits at bank1 bit 2 but index 8; PIN2_SRC is 9 and is used nowhere

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire logic wr_en2  = reg_wr_i & hit(reg_addr_i, `OFS_ENABLE2);
    wire logic wr_glb  = reg_wr_i & hit(reg_addr_i, `OFS_GLOBAL_EN);
    wire logic wr_lo0  = reg_wr_i & hit(reg_addr_i, `OFS_PRIO_LO0);
    wire logic wr_hi0  = reg_wr_i & hit(reg_addr_i, `OFS_PRIO_HI0);
    wire logic wr_lo1  = reg_wr_i & hit(reg_addr_i, `OFS_PRIO_LO1);
    wire logic wr_hi1  = reg_wr_i & hit(reg_addr_i, `OFS_PRIO_HI1);
    wire logic wr_clr  = reg_wr_i & hit(reg_addr_i, `OFS_CLEAR);
    wire logic wr_een  = reg_wr_i & hit(reg_addr_i, `OFS_EVT_EN);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]      enable2_q;
    logic [7:0]      global_q;
    logic [7:0]      prio_lo0_q;
    logic [7:0]      prio_hi0_q;
    logic [7:0]      prio_lo1_q;
    logic [7:0]      prio_hi1_q;
    logic [NSRC-1:0] flag_q;
    logic [2:0]      evt_q;
    logic [2:0]      evt_en_q;
    logic [3:0]      active_q;
    logic [7:0]      rdata_q;
    grant_s          grant_q;
    logic            stop_wake_q;
    logic            irq_q;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            enable2_q  <= `RST_BYTE;  // [RULE14]
            global_q   <= `RST_BYTE;
            prio_lo0_q <= `RST_BYTE;
            prio_hi0_q <= `RST_BYTE;
            prio_lo1_q <= `RST_BYTE;
            prio_hi1_q <= `RST_BYTE;
        end else begin
            if (wr_en2) enable2_q  <= reg_wdata_i & `MASK_ENABLE2;  // [RULE14]
            if (wr_glb) global_q   <= reg_wdata_i & `MASK_GLOBAL;
            if (wr_lo0) prio_lo0_q <= reg_wdata_i & `MASK_PRIO0;
            if (wr_hi0) prio_hi0_q <= reg_wdata_i & `MASK_PRIO0;
            if (wr_lo1) prio_lo1_q <= reg_wdata_i & `MASK_PRIO1;
            if (wr_hi1) prio_hi1_q <= reg_wdata_i & `MASK_PRIO1;
        end
    end

    // ----------------------------------------
    // Named fields
    // ----------------------------------------
    // Second enable register  [RULE14]
    wire logic serial_periph_irq_en = enable2_q[4];
    wire logic touch_irq_en         = enable2_q[3];
    wire logic pin2_irq_en          = enable2_q[`BIT_PIN2_EN];
    wire logic port_change_irq_en   = enable2_q[1];
    wire logic rtc_timer_irq_en     = enable2_q[0];
    wire logic flash_write_en       = enable2_q[`BIT_FLASH_WE];

    // Global enable register
    wire logic global_irq_en        = global_q[`BIT_GLOBAL_EN];
    wire logic timer2_irq_en        = global_q[5];
    wire logic serial_irq_en        = global_q[4];
    wire logic timer1_irq_en        = global_q[3];
    wire logic pin1_irq_en          = global_q[2];
    wire logic timer0_irq_en        = global_q[1];
    wire logic pin0_irq_en          = global_q[0];

    // Priority bank0
    wire logic timer2_prio_hi       = prio_hi0_q[5];
    wire logic serial_prio_hi       = prio_hi0_q[4];
    wire logic timer1_prio_hi       = prio_hi0_q[3];
    wire logic pin1_prio_hi         = prio_hi0_q[2];
    wire logic timer0_prio_hi       = prio_hi0_q[1];
    wire logic pin0_prio_hi         = prio_hi0_q[0];
    wire logic timer2_prio_lo       = prio_lo0_q[5];
    wire logic serial_prio_lo       = prio_lo0_q[4];
    wire logic timer1_prio_lo       = prio_lo0_q[3];
    wire logic pin1_prio_lo         = prio_lo0_q[2];
    wire logic timer0_prio_lo       = prio_lo0_q[1];
    wire logic pin0_prio_lo         = prio_lo0_q[0];

    // Priority bank1
    wire logic spi_prio_hi          = prio_hi1_q[4];
    wire logic touch_prio_hi        = prio_hi1_q[3];
    wire logic pin2_prio_hi         = prio_hi1_q[2];
    wire logic port_change_prio_hi  = prio_hi1_q[1];
    wire logic rtc_timer_prio_hi    = prio_hi1_q[0];
    wire logic spi_prio_lo          = prio_lo1_q[4];
    wire logic touch_prio_lo        = prio_lo1_q[3];
    wire logic pin2_prio_lo         = prio_lo1_q[2];
    wire logic port_change_prio_lo  = prio_lo1_q[1];
    wire logic rtc_timer_prio_lo    = prio_lo1_q[0];

    // ----------------------------------------
    // Per-source enable and level
    // ----------------------------------------
    wire logic [NSRC-1:0] src_en;
    wire logic [NSRC-1:0] prio_hi;
    wire logic [NSRC-1:0] prio_lo;

    // Bank0 sources
    assign src_en[0]  = pin0_irq_en;
    assign prio_hi[0] = pin0_prio_hi;         // [RULE7]
    assign prio_lo[0] = pin0_prio_lo;         // [RULE7]

    assign src_en[1]  = timer0_irq_en;
    assign prio_hi[1] = timer0_prio_hi;       // [RULE6]
    assign prio_lo[1] = timer0_prio_lo;       // [RULE6]

    assign src_en[2]  = pin1_irq_en;
    assign prio_hi[2] = pin1_prio_hi;         // [RULE5]
    assign prio_lo[2] = pin1_prio_lo;         // [RULE5]

    assign src_en[3]  = timer1_irq_en;
    assign prio_hi[3] = timer1_prio_hi;       // [RULE4]
    assign prio_lo[3] = timer1_prio_lo;       // [RULE4]

    assign src_en[4]  = serial_irq_en;
    assign prio_hi[4] = serial_prio_hi;       // [RULE3]
    assign prio_lo[4] = serial_prio_lo;       // [RULE3]

    assign src_en[5]  = timer2_irq_en;
    assign prio_hi[5] = timer2_prio_hi;       // [RULE2]
    assign prio_lo[5] = timer2_prio_lo;       // [RULE2]

    // Bank1 sources
    assign src_en[6]  = rtc_timer_irq_en;     // [RULE13]
    assign prio_hi[6] = rtc_timer_prio_hi;    // [RULE12]
    assign prio_lo[6] = rtc_timer_prio_lo;    // [RULE12]

    assign src_en[7]  = port_change_irq_en;
    assign prio_hi[7] = port_change_prio_hi;  // [RULE11]
    assign prio_lo[7] = port_change_prio_lo;  // [RULE11]

    assign src_en[8]  = pin2_irq_en;
    assign prio_hi[8] = pin2_prio_hi;         // [RULE10]
    assign prio_lo[8] = pin2_prio_lo;         // [RULE10]

    assign src_en[9]  = touch_irq_en;
    assign prio_hi[9] = touch_prio_hi;        // [RULE9]
    assign prio_lo[9] = touch_prio_lo;        // [RULE9]

    assign src_en[10]  = serial_periph_irq_en;
    assign prio_hi[10] = spi_prio_hi;         // [RULE8]
    assign prio_lo[10] = spi_prio_lo;         // [RULE8]

    // Serviceable only with own and global enable  [RULE13]
    wire logic [NSRC-1:0] pending = flag_q & src_en & {NSRC{global_irq_en}};

    prio_t lvl [NSRC];
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_lvl
            assign lvl[g] = {prio_hi[g], prio_lo[g]};  // [RULE1]
        end
    endgenerate

    // ----------------------------------------
    // Arbitration
    // ----------------------------------------
    // Highest level wins; within a level the lowest index wins
    grant_s pick;
    always_comb begin
        pick = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pending[i] && (!pick.valid || lvl[i] >= pick.level)) begin
                pick.valid  = 1'b1;
                pick.source = 4'(i);
                pick.level  = lvl[i];
            end
        end
    end

    // Level of the running routine, or none
    wire logic       any_active = |active_q;
    logic [1:0]      top_level;
    always_comb begin
        top_level = 2'd0;
        for (int k = 0; k < 4; k++) begin
            if (active_q[k]) top_level = 2'(k);
        end
    end
    wire logic may_enter = pick.valid && (!any_active || pick.level > top_level);  // [RULE16] [RULE17]

    // ----------------------------------------
    // Flags and nesting
    // ----------------------------------------
    wire logic [NSRC-1:0] ack_clr = (ack_i && grant_q.valid) ? (NSRC'(1) << grant_q.source) : '0;

    wire logic [3:0] top_onehot = any_active ? (4'h1 << top_level) : 4'h0;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            flag_q      <= `RST_SRC;
            active_q    <= 4'h0;
            grant_q     <= '0;
            stop_wake_q <= 1'b0;
        end else begin
            // Event wins over clear, independent of enable  [RULE18]
            flag_q <= (flag_q & ~src_flag_clr_i & ~ack_clr) | src_event_i;
            // Nested levels: ack pushes, return pops the top  [RULE16]
            if (ack_i && grant_q.valid) begin
                active_q <= (active_q | (4'h1 << grant_q.level));
            end else if (reti_i) begin
                active_q <= active_q & ~top_onehot;
            end
            // Held request stays until it may enter  [RULE17]
            if (ack_i && grant_q.valid) begin
                grant_q <= '0;
            end else begin
                grant_q.valid  <= may_enter;
                grant_q.source <= pick.source;
                grant_q.level  <= pick.level;
            end
            // Pin 2 wakes from stop whatever the global enable  [RULE15]
            stop_wake_q <= stop_mode_i &&
                           ((flag_q[8] | src_event_i[8]) && pin2_irq_en);
        end
    end

    // ----------------------------------------
    // Event status and interrupt line
    // ----------------------------------------
    // Bit 0 grant acknowledged, bit 1 preemption, bit 2 stop wake
    wire logic [2:0] evt_set = {stop_wake_q, may_enter & any_active, ack_i & grant_q.valid};

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            evt_q    <= `RST_EVT;
            evt_en_q <= `RST_EVT;
            irq_q    <= 1'b0;
        end else begin
            evt_q <= (evt_q & ~(wr_clr ? reg_wdata_i[2:0] : 3'h0)) | evt_set;
            if (wr_een) evt_en_q <= reg_wdata_i[2:0];
            irq_q <= |(evt_q & evt_en_q);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr_i)
            `OFS_ENABLE2:   rd_mux = enable2_q;
            `OFS_GLOBAL_EN: rd_mux = global_q;
            `OFS_PRIO_LO0:  rd_mux = prio_lo0_q;
            `OFS_PRIO_HI0:  rd_mux = prio_hi0_q;
            `OFS_PRIO_LO1:  rd_mux = prio_lo1_q;
            `OFS_PRIO_HI1:  rd_mux = prio_hi1_q;
            `OFS_STATUS:    rd_mux = {5'h00, evt_q};
            `OFS_EVT_EN:    rd_mux = {5'h00, evt_en_q};
            `OFS_SERVICE:   rd_mux = {4'h0, active_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) rdata_q <= `RST_BYTE;
        else          rdata_q <= reg_rd_i ? rd_mux : 8'h00;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic flash_we_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) flash_we_q <= 1'b0;
        else          flash_we_q <= flash_write_en;
    end

    assign reg_rdata_o      = rdata_q;
    assign src_flag_o       = flag_q;
    assign req_o            = grant_q.valid;
    assign req_src_o        = grant_q.source;
    assign req_level_o      = grant_q.level;
    assign stop_wake_o      = stop_wake_q;
    assign flash_write_en_o = flash_we_q;
    assign irq_o            = irq_q;

endmodule // irq_prio_ctrl

// *** testbench/core_model.sv ***
// Core side model that takes requests and returns from routines
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // Request side
    input  wire logic req_i,
    input  wire logic slow_i,
    input  wire logic ret_cmd_i,
    output logic      ack_o,
    output logic      reti_o
);
    logic [1:0] wait_q;
    // Prompt or four-cycle acceptance, one-cycle pulses
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            wait_q <= 2'h0;
            ack_o  <= 1'b0;
            reti_o <= 1'b0;
        end else begin
            wait_q <= (req_i && !ack_o) ? wait_q + 2'h1 : 2'h0;
            ack_o  <= req_i && !ack_o && (!slow_i || wait_q == 2'h3);
            reti_o <= ret_cmd_i;
        end
    end
endmodule // core_model

// *** testbench/irq_prio_ctrl_chk.sv ***
// Checker for the interrupt enable and priority block
`timescale 1ns/1ps
`include "irq_prio_regs.svh"
module irq_prio_ctrl_chk #(
    parameter int NSRC = 11
) (
    // Clock, reset, register port
    input wire logic            clk_sys_i,
    input wire logic            rst_b_i,
    input wire logic [7:0]      reg_addr_i,
    input wire logic [7:0]      reg_wdata_i,
    input wire logic            reg_wr_i,
    input wire logic            reg_rd_i,
    input wire logic [7:0]      reg_rdata_o,
    // Sources and core
    input wire logic [NSRC-1:0] src_event_i,
    input wire logic [NSRC-1:0] src_flag_o,
    input wire logic            ack_i,
    input wire logic            stop_mode_i,
    input wire logic            req_o,
    input wire logic [3:0]      req_src_o,
    input wire logic [1:0]      req_level_o,
    input wire logic            stop_wake_o,
    input wire logic            flash_write_en_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Shadow of timer3 enable, pin2 enable, timer3 level
    logic [3:0] sh_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i)
            sh_q <= 4'h0;
        else if (reg_wr_i && reg_addr_i == `OFS_ENABLE2)
            sh_q[3:2] <= {reg_wdata_i[0], reg_wdata_i[2]};
        else if (reg_wr_i && reg_addr_i == `OFS_PRIO_HI1)
            sh_q[1] <= reg_wdata_i[0];
        else if (reg_wr_i && reg_addr_i == `OFS_PRIO_LO1)
            sh_q[0] <= reg_wdata_i[0];
    end
    sequence s_pin2_evt;
        stop_mode_i && sh_q[2] && src_event_i[8];
    endsequence
    property p_flash;
        logic w;
        (reg_wr_i && reg_addr_i == `OFS_ENABLE2, w = reg_wdata_i[6]) |-> ##2 flash_write_en_o == w;
    endproperty
    a_read_idle:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("stale read data");
    a_flag_set:
        assert property ((|src_event_i) |=> (src_flag_o & $past(src_event_i)) == $past(src_event_i))
            else $error("flag not set");
    a_req_stands:
        assert property (req_o && !ack_i |=> req_o) else $error("request dropped");
    a_req_flag:
        assert property (req_o |-> src_flag_o[req_src_o]) else $error("request without flag");
    a_rtc_gate:
        assert property (req_o && req_src_o == 4'h6 |-> sh_q[3]) else $error("timer3 not gated");
    a_rtc_level:
        assert property (req_o && req_src_o == 4'h6 |-> req_level_o == sh_q[1:0]) else $error("timer3 level");
    a_wake_pin2:
        assert property (s_pin2_evt ##1 stop_mode_i [*2] |-> stop_wake_o) else $error("no wake");
    a_flash_copy:
        assert property (p_flash) else $error("flash enable copy");
endmodule // irq_prio_ctrl_chk

bind irq_prio_ctrl irq_prio_ctrl_chk #(.NSRC(NSRC)) u_chk (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .src_event_i, .src_flag_o, .ack_i, .stop_mode_i, .req_o, .req_src_o,
    .req_level_o, .stop_wake_o, .flash_write_en_o);

// *** testbench/test_irq_prio_ctrl.sv ***
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`include "irq_prio_regs.svh"
module test_irq_prio_ctrl;
    logic clk_sys_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, stop_mode_i = 1'b0;
    logic slow_i = 1'b0, ret_cmd_i = 1'b0, ack_i, reti_i, req_o, stop_wake_o, flash_write_en_o, irq_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, m;
    logic [10:0] src_event_i = 11'h000, src_flag_clr_i = 11'h000, src_flag_o;
    logic [3:0] req_src_o;
    logic [1:0] req_level_o, l;
    int n_fail = 0, n_compared = 0, cyc = 0, s;
    localparam logic [7:0] ADR [5] = '{`OFS_ENABLE2, `OFS_PRIO_LO0, `OFS_PRIO_HI0, `OFS_PRIO_LO1, `OFS_PRIO_HI1};
    localparam logic [7:0] MSK [5] = '{`MASK_ENABLE2, `MASK_PRIO0, `MASK_PRIO0, `MASK_PRIO1, `MASK_PRIO1};
    always #4 clk_sys_i = ~clk_sys_i;
    irq_prio_ctrl u_dut (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .src_event_i, .src_flag_clr_i, .src_flag_o, .ack_i, .reti_i, .stop_mode_i, .req_o, .req_src_o,
        .req_level_o, .stop_wake_o, .flash_write_en_o, .irq_o);
    core_model u_core (.clk_sys_i, .rst_b_i, .req_i(req_o), .slow_i, .ret_cmd_i, .ack_o(ack_i), .reti_o(reti_i));
    task automatic end_sim;
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(11'(reg_rdata_o), 11'(e));
    endtask
    task automatic ev(input logic [10:0] d);
        @(posedge clk_sys_i);
        src_event_i <= d;
        @(posedge clk_sys_i);
        src_event_i <= 11'h000;
    endtask
    task automatic ret;
        @(posedge clk_sys_i);
        ret_cmd_i <= 1'b1;
        @(posedge clk_sys_i);
        ret_cmd_i <= 1'b0;
    endtask
    task automatic done(input int n);
        @(posedge clk_sys_i);
        src_flag_clr_i <= 11'h7FF;
        @(posedge clk_sys_i);
        src_flag_clr_i <= 11'h000;
        repeat (n) ret();
    endtask
    task automatic wfor(ref logic sig, input logic e);
        #1;
        for (int i = 0; i < 8 && sig !== e; i++)
            @(posedge clk_sys_i) #1;
        chk(11'(sig), 11'(e));
    endtask
    task automatic hold(ref logic sig, input logic e);
        repeat (5) begin
            @(posedge clk_sys_i) #1;
            chk(11'(sig), 11'(e));
        end
    endtask
    task automatic wq(input logic [3:0] src, input logic [1:0] lvl);
        wfor(req_o, 1'b1);
        chk(11'({req_src_o, req_level_o}), 11'({src, lvl}));
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        for (s = 0; s < 5; s++) begin
            rdc(ADR[s], 8'h00);
            wrt(ADR[s], 8'hFF);
            rdc(ADR[s], MSK[s]);
        end
        chk(11'(flash_write_en_o), 11'h001);
        wrt(8'h50, 8'hFF);
        rdc(8'h50, 8'h00);
        wrt(`OFS_GLOBAL_EN, 8'hBF);
        wrt(`OFS_ENABLE2, 8'h1F);
        // Each source alone above the rest, levels 1 to 3
        for (s = 0; s < 11; s++) begin
            l = 2'(s % 3 + 1);
            m = 8'h01 << (s > 5 ? s - 6 : s);
            wrt(`OFS_PRIO_LO0, (s < 6 && l[0]) ? m : 8'h00);
            wrt(`OFS_PRIO_HI0, (s < 6 && l[1]) ? m : 8'h00);
            wrt(`OFS_PRIO_LO1, (s > 5 && l[0]) ? m : 8'h00);
            wrt(`OFS_PRIO_HI1, (s > 5 && l[1]) ? m : 8'h00);
            ev(11'h7FF);
            wq(4'(s), l);
            done(1);
        end
        wrt(`OFS_PRIO_HI1, 8'h00);
        wrt(`OFS_ENABLE2, 8'h1E);
        ev(11'h040);
        hold(req_o, 1'b0);
        chk(src_flag_o, 11'h040);
        wrt(`OFS_ENABLE2, 8'h1F);
        wq(4'h6, 2'h0);
        done(1);
        // Nesting with a slow core
        slow_i <= 1'b1;
        wrt(`OFS_PRIO_LO0, 8'h07);
        wrt(`OFS_PRIO_HI0, 8'h06);
        ev(11'h001);
        wq(4'h0, 2'h1);
        wfor(req_o, 1'b0);
        ev(11'h002);
        wq(4'h1, 2'h3);
        wfor(req_o, 1'b0);
        ev(11'h004);
        hold(req_o, 1'b0);
        ret();
        wq(4'h2, 2'h3);
        wfor(req_o, 1'b0);
        done(2);
        slow_i <= 1'b0;
        // Stop wake from pin 2 with global enable off
        wrt(`OFS_GLOBAL_EN, 8'h00);
        wrt(`OFS_ENABLE2, 8'h1B);
        stop_mode_i <= 1'b1;
        ev(11'h100);
        hold(stop_wake_o, 1'b0);
        done(0);
        wrt(`OFS_ENABLE2, 8'h1F);
        ev(11'h100);
        wfor(stop_wake_o, 1'b1);
        chk(11'(req_o), 11'h000);
        @(posedge clk_sys_i);
        stop_mode_i <= 1'b0;
        done(0);
        // Status, event enable and interrupt line
        rdc(`OFS_STATUS, 8'h07);
        wrt(`OFS_STATUS, 8'h00);
        rdc(`OFS_STATUS, 8'h07);
        chk(11'(irq_o), 11'h000);
        wrt(`OFS_EVT_EN, 8'h04);
        wfor(irq_o, 1'b1);
        wrt(`OFS_EVT_EN, 8'h00);
        wfor(irq_o, 1'b0);
        wrt(`OFS_EVT_EN, 8'h07);
        wfor(irq_o, 1'b1);
        wrt(`OFS_CLEAR, 8'h07);
        wfor(irq_o, 1'b0);
        rdc(`OFS_STATUS, 8'h00);
        end_sim();
    end
endmodule // test_irq_prio_ctrl
